/* glt_ctrl.sv */
// guard lock teach controller: pairing, solenoid control, safety outputs and lamps
`timescale 1ns/1ps
`default_nettype none

module glt_ctrl import glt_pkg::*; #(
  parameter int                   CODE_W      = GLT_CODE_W,
  parameter logic [GLT_TMR_W-1:0] TEACH_CYC   = GLT_TMR_W'(GLT_TEACH_CYC),
  parameter logic [GLT_TMR_W-1:0] OFFREQ_CYC  = GLT_TMR_W'(GLT_OFFREQ_CYC),
  parameter logic [GLT_TMR_W-1:0] HOLDOFF_CYC = GLT_TMR_W'(GLT_HOLDOFF_CYC),
  parameter logic [GLT_TICK_W-1:0] TICK_CYC   = GLT_TICK_W'(GLT_TICK_CYC)
) (
  input  wire logic              SYS_CLK,
  input  wire logic              RST_N,
  input  wire logic              CE,
  input  wire logic              PSEL,
  input  wire logic              PENABLE,
  input  wire logic              PWRITE,
  input  wire logic [7:0]        PADDR,
  input  wire logic [31:0]       PWDATA,
  output var  logic [31:0]       PRDATA,
  output var  logic              PREADY,
  output var  logic              PSLVERR,
  input  wire logic              ACT_PRESENT,
  input  wire logic [CODE_W-1:0] ACT_CODE,
  input  wire logic              CHAIN_SAFE_IN_A,
  input  wire logic              CHAIN_SAFE_IN_B,
  input  wire logic              LOCK_CMD,
  input  wire logic              HANDLE_AT_DETENT,
  input  wire logic              LOCK_SENSE,
  input  wire logic [2:0]        NV_FLAGS,
  input  wire logic [CODE_W-1:0] NV_CODE,
  input  wire logic [CODE_W-1:0] NV_NEW_CODE,
  output var  logic              NV_WE,
  output var  logic [2:0]        NV_WFLAGS,
  output var  logic [CODE_W-1:0] NV_WCODE,
  output var  logic [CODE_W-1:0] NV_WNEW_CODE,
  output var  logic              LOCK_DRIVE,
  output var  logic              SAFE_OUT_A,
  output var  logic              SAFE_OUT_B,
  output var  logic              LAMP_POWER,
  output var  logic              LAMP_STATUS,
  output var  logic              LAMP_FAULT
);

  localparam int SYNC_W = 6 + 3 + 3 * CODE_W;

  function automatic logic tmr_done(input logic [GLT_TMR_W-1:0] t, input logic [GLT_TMR_W-1:0] lim);
    tmr_done = (t >= lim - GLT_TMR_W'(1));
  endfunction

  function automatic logic code_eq(input logic [CODE_W-1:0] a, input logic [CODE_W-1:0] b);
    code_eq = (a == b);
  endfunction

  // pin synchroniser; the first stage feeds only the second
  logic [SYNC_W-1:0]     sync1_q;
  logic [SYNC_W-1:0]     sync2_q;
  logic                  act_present;
  logic [CODE_W-1:0]     act_code;
  logic                  chain_a;
  logic                  chain_b;
  logic                  lock_cmd;
  logic                  handle_ok;
  logic                  lock_sense;
  logic [2:0]            nv_flags_in;
  logic [CODE_W-1:0]     nv_code_in;
  logic [CODE_W-1:0]     nv_new_in;

  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      sync1_q <= '0;
      sync2_q <= '0;
    end else if (CE) begin
      sync1_q <= {ACT_PRESENT, CHAIN_SAFE_IN_A, CHAIN_SAFE_IN_B, LOCK_CMD, HANDLE_AT_DETENT,
                  LOCK_SENSE, NV_FLAGS, ACT_CODE, NV_CODE, NV_NEW_CODE};
      sync2_q <= sync1_q;
    end
  end

  assign {act_present, chain_a, chain_b, lock_cmd, handle_ok, lock_sense, nv_flags_in,
          act_code, nv_code_in, nv_new_in} = sync2_q;

  // control register
  logic [GLT_CTRL_W-1:0] ctrl_q;
  logic                  cfg_indiv;
  logic                  cfg_repeat;
  logic                  cfg_p2lock;
  logic                  cfg_lockmon;

  assign cfg_indiv   = ctrl_q[GLT_CTRL_INDIV_BIT];
  assign cfg_repeat  = ctrl_q[GLT_CTRL_REPEAT_BIT];
  assign cfg_p2lock  = ctrl_q[GLT_CTRL_P2LOCK_BIT];
  assign cfg_lockmon = ctrl_q[GLT_CTRL_LOCKMON_BIT];

  // one timebase for every blink
  logic [GLT_TICK_W-1:0] tick_cnt_q;
  logic [1:0]            slow_div_q;
  logic                  fast_ph_q;
  logic                  slow_ph_q;
  logic                  tick;
  logic                  slow_edge;

  assign tick      = (tick_cnt_q == TICK_CYC - GLT_TICK_W'(1));
  assign slow_edge = tick && (slow_div_q == 2'(GLT_TICKS_PER_SLOW - 1));

  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      tick_cnt_q <= '0;
      slow_div_q <= '0;
      fast_ph_q  <= 1'b0;
      slow_ph_q  <= 1'b0;
    end else if (CE) begin
      tick_cnt_q <= tick ? '0 : tick_cnt_q + GLT_TICK_W'(1);
      if (tick) begin
        fast_ph_q  <= ~fast_ph_q;
        slow_div_q <= slow_edge ? 2'd0 : slow_div_q + 2'd1;
      end
      if (slow_edge) begin
        slow_ph_q <= ~slow_ph_q;
      end
    end
  end

  // sequence state, persistent copy and write-back
  glt_state_t            state_q;
  logic [GLT_TMR_W-1:0]  tmr_q;
  logic                  fresh_q;
  logic                  hold_done_q;
  logic                  hold_seen_q;
  logic [3:0]            flash_q;
  logic [2:0]            flags_q;
  logic [CODE_W-1:0]     code_q;
  logic [CODE_W-1:0]     new_q;
  logic                  paired;
  logic                  pending;
  logic                  holdoff;
  logic                  pair_allowed;
  logic                  act_ok;

  assign paired   = flags_q[GLT_NV_PAIRED];
  assign pending  = flags_q[GLT_NV_PENDING];
  assign holdoff  = flags_q[GLT_NV_HOLDOFF];
  // one-time units refuse pairing once allocated
  assign pair_allowed = cfg_repeat || !paired;
  // standard coding needs no stored code at all
  assign act_ok = act_present && (!cfg_indiv ||
                  (paired && !pending && code_eq(act_code, code_q)));

  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      state_q     <= ST_INIT;
      tmr_q       <= '0;
      fresh_q     <= 1'b1;
      hold_done_q <= 1'b0;
      hold_seen_q <= 1'b0;
      flash_q     <= '0;
      flags_q     <= '0;
      code_q      <= '0;
      new_q       <= '0;
      NV_WE       <= 1'b0;
      NV_WFLAGS   <= '0;
      NV_WCODE    <= '0;
      NV_WNEW_CODE <= '0;
    end else if (CE) begin
      NV_WE <= 1'b0;
      if (state_q == ST_INIT || state_q == ST_HOLDOFF || state_q == ST_TEACH || state_q == ST_OFFREQ) begin
        tmr_q <= tmr_q + GLT_TMR_W'(1);
      end
      case (state_q)
        ST_INIT: begin
          // wait for the synchroniser to fill, then take the stored word
          if (tmr_q == GLT_TMR_W'(GLT_INIT_WAIT)) begin
            flags_q <= nv_flags_in;
            code_q  <= nv_code_in;
            new_q   <= nv_new_in;
            tmr_q   <= '0;
            if (nv_flags_in[GLT_NV_PENDING]) begin
              state_q <= ST_ACTIVATE;
            end else if (nv_flags_in[GLT_NV_HOLDOFF]) begin
              state_q <= ST_HOLDOFF;
            end else begin
              state_q <= ST_RUN;
            end
          end
        end
        ST_RUN: begin
          if (fresh_q && act_present) begin
            fresh_q <= 1'b0;
            if (cfg_indiv && pair_allowed && (!paired || !code_eq(act_code, code_q))) begin
              state_q <= ST_TEACH;
              tmr_q   <= '0;
            end
          end
        end
        ST_TEACH: begin
          if (!act_present) begin
            state_q <= ST_RUN;
          end else if (tmr_done(tmr_q, TEACH_CYC)) begin
            // the old code stops counting until the off-request period runs out
            new_q             <= act_code;
            flags_q           <= flags_q | (3'b001 << GLT_NV_PENDING);
            NV_WE             <= 1'b1;
            NV_WFLAGS         <= flags_q | (3'b001 << GLT_NV_PENDING);
            NV_WCODE          <= code_q;
            NV_WNEW_CODE      <= act_code;
            state_q           <= ST_OFFREQ;
            tmr_q             <= '0;
          end
        end
        ST_OFFREQ: begin
          if (tmr_done(tmr_q, OFFREQ_CYC)) begin
            flags_q      <= flags_q & ~(3'b001 << GLT_NV_PENDING);
            NV_WE        <= 1'b1;
            NV_WFLAGS    <= flags_q & ~(3'b001 << GLT_NV_PENDING);
            NV_WCODE     <= code_q;
            NV_WNEW_CODE <= new_q;
            state_q      <= ST_ABORT;
            flash_q      <= '0;
          end
        end
        ST_ABORT: begin
          if (slow_edge) begin
            if (flash_q == 4'(2 * GLT_ABORT_FLASHES - 1)) begin
              state_q <= ST_RUN;
            end else begin
              flash_q <= flash_q + 4'd1;
            end
          end
        end
        ST_ACTIVATE: begin
          // only a second detection of the learned code makes it permanent
          if (act_present && code_eq(act_code, new_q)) begin
            code_q       <= new_q;
            flags_q      <= {cfg_repeat, 1'b0, 1'b1};
            NV_WE        <= 1'b1;
            NV_WFLAGS    <= {cfg_repeat, 1'b0, 1'b1};
            NV_WCODE     <= new_q;
            NV_WNEW_CODE <= new_q;
            tmr_q        <= '0;
            hold_done_q  <= 1'b0;
            hold_seen_q  <= 1'b0;
            state_q      <= cfg_repeat ? ST_HOLDOFF : ST_RUN;
          end
        end
        ST_HOLDOFF: begin
          // the stored flag survives a power loss, so the period starts over
          if (act_ok) begin
            hold_seen_q <= 1'b1;
          end
          if (!hold_done_q && tmr_done(tmr_q, HOLDOFF_CYC)) begin
            hold_done_q  <= 1'b1;
            flags_q      <= flags_q & ~(3'b001 << GLT_NV_HOLDOFF);
            NV_WE        <= 1'b1;
            NV_WFLAGS    <= flags_q & ~(3'b001 << GLT_NV_HOLDOFF);
            NV_WCODE     <= code_q;
            NV_WNEW_CODE <= new_q;
          end
          if (hold_done_q && (hold_seen_q || act_ok)) begin
            state_q <= ST_RUN;
          end
        end
        default: begin
          state_q <= ST_INIT;
        end
      endcase
    end
  end

  // solenoid and safety outputs
  logic lock_req;
  logic chain_ok;
  logic out_en;

  assign lock_req = cfg_p2lock ? lock_cmd : !lock_cmd;
  assign chain_ok = chain_a && chain_b;
  // lock-monitoring follows the bolt, guard-monitoring only the actuator
  assign out_en   = (state_q == ST_RUN) && act_ok && chain_ok &&
                    (!cfg_lockmon || lock_sense);

  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      LOCK_DRIVE <= 1'b0;
      SAFE_OUT_A <= 1'b0;
      SAFE_OUT_B <= 1'b0;
    end else if (CE) begin
      // a handle between detents would jam the bolt, so never energise
      LOCK_DRIVE <= lock_req && act_ok && handle_ok &&
                    (state_q == ST_RUN || state_q == ST_HOLDOFF);
      SAFE_OUT_A <= out_en;
      SAFE_OUT_B <= out_en;
    end
  end

  // lamps
  logic status_lamp;

  assign status_lamp = !act_ok ? 1'b0 : (lock_sense ? 1'b1 : slow_ph_q);

  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      LAMP_POWER  <= 1'b0;
      LAMP_STATUS <= 1'b0;
      LAMP_FAULT  <= 1'b0;
    end else if (CE) begin
      case (state_q)
        ST_TEACH: begin
          LAMP_POWER  <= 1'b0;
          LAMP_STATUS <= slow_ph_q;
          LAMP_FAULT  <= 1'b1;
        end
        ST_OFFREQ: begin
          LAMP_POWER  <= 1'b0;
          LAMP_STATUS <= fast_ph_q;
          LAMP_FAULT  <= 1'b1;
        end
        ST_ABORT: begin
          LAMP_POWER  <= 1'b1;
          LAMP_STATUS <= 1'b0;
          LAMP_FAULT  <= !flash_q[0];
        end
        ST_ACTIVATE: begin
          LAMP_POWER  <= 1'b1;
          LAMP_STATUS <= slow_ph_q;
          LAMP_FAULT  <= 1'b0;
        end
        ST_HOLDOFF: begin
          LAMP_POWER  <= slow_ph_q;
          LAMP_STATUS <= 1'b0;
          LAMP_FAULT  <= 1'b0;
        end
        ST_RUN: begin
          LAMP_POWER  <= chain_ok ? 1'b1 : slow_ph_q;
          LAMP_STATUS <= status_lamp;
          LAMP_FAULT  <= 1'b0;
        end
        default: begin
          LAMP_POWER  <= 1'b1;
          LAMP_STATUS <= 1'b0;
          LAMP_FAULT  <= 1'b0;
        end
      endcase
    end
  end

  // apb slave: one wait-free access phase, unmapped offsets answer with an error
  logic        apb_setup;
  logic        apb_access;
  logic        hit_ctrl;
  logic        hit_status;
  logic [31:0] status_word;

  assign apb_setup  = PSEL && !PENABLE;
  assign apb_access = PSEL && PENABLE && PREADY;
  assign hit_ctrl   = (PADDR == GLT_CTRL_OFS);
  assign hit_status = (PADDR == GLT_STATUS_OFS);

  always_comb begin
    status_word = '0;
    status_word[GLT_ST_STATE_LSB +: 7] = state_q;
    status_word[GLT_ST_PAIRED_BIT]     = paired;
    status_word[GLT_ST_PENDING_BIT]    = pending;
    status_word[GLT_ST_HOLDOFF_BIT]    = holdoff;
    status_word[GLT_ST_GUARD_BIT]      = act_ok;
    status_word[GLT_ST_LOCKED_BIT]     = lock_sense;
    status_word[GLT_ST_SAFE_BIT]       = SAFE_OUT_A;
    status_word[GLT_ST_CHAIN_BIT]      = chain_ok;
    status_word[GLT_ST_HANDLE_BIT]     = handle_ok;
  end

  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      PREADY  <= 1'b0;
      PRDATA  <= '0;
      PSLVERR <= 1'b0;
    end else if (CE) begin
      PREADY  <= apb_setup;
      PSLVERR <= apb_setup && !hit_ctrl && !hit_status;
      if (apb_setup && !PWRITE) begin
        PRDATA <= hit_ctrl   ? {{(32 - GLT_CTRL_W){1'b0}}, ctrl_q} :
                  hit_status ? status_word : 32'h0000_0000;
      end
    end
  end

  // variant bits may change at any time; they act on the next cycle
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      ctrl_q <= GLT_CTRL_RESET;
    end else if (CE) begin
      if (apb_access && PWRITE && hit_ctrl) begin
        ctrl_q <= PWDATA[GLT_CTRL_W-1:0];
      end
    end
  end

endmodule

`default_nettype wire

/* glt_ctrl_monitor.sv */
// concurrent checks on the guard lock teach controller ports
`timescale 1ns/1ps
`default_nettype none
module glt_ctrl_monitor import glt_pkg::*; #(
  parameter logic [GLT_TMR_W-1:0] HOLDOFF_CYC = 34'h32
) (
  input wire logic       SYS_CLK,
  input wire logic       RST_N,
  input wire logic       PSEL,
  input wire logic       PENABLE,
  input wire logic       PREADY,
  input wire logic       ACT_PRESENT,
  input wire logic       CHAIN_SAFE_IN_A,
  input wire logic       HANDLE_AT_DETENT,
  input wire logic       NV_WE,
  input wire logic [2:0] NV_WFLAGS,
  input wire logic       LOCK_DRIVE,
  input wire logic       SAFE_OUT_A,
  input wire logic       SAFE_OUT_B,
  input wire logic       LAMP_POWER,
  input wire logic       LAMP_FAULT
);
  logic [GLT_TMR_W-1:0] hold_q;
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (!RST_N);
  // two cycles short of the full period so the exit edge never fires falsely
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      hold_q <= '0;
    end else if (NV_WE && NV_WFLAGS[GLT_NV_HOLDOFF]) begin
      hold_q <= HOLDOFF_CYC - 34'h2;
    end else if (hold_q != '0) begin
      hold_q <= hold_q - 34'h1;
    end
  end
  a_pair_equal: assert property (SAFE_OUT_A == SAFE_OUT_B)
    else $error("safety outputs differ");
  a_handle_no_lock: assert property (!HANDLE_AT_DETENT |-> ##3 !LOCK_DRIVE)
    else $error("lock driven with handle between detents");
  a_guard_open_off: assert property (!ACT_PRESENT ##3 1'b1 |-> !SAFE_OUT_A)
    else $error("outputs on with guard open");
  a_chain_off: assert property ($past(CHAIN_SAFE_IN_A, 3) == 1'b0 |-> !SAFE_OUT_B)
    else $error("outputs on with chain input missing");
  a_holdoff_off: assert property (hold_q != '0 |-> !SAFE_OUT_A)
    else $error("outputs on during hold-off");
  a_safe_lamps: assert property (SAFE_OUT_A |-> LAMP_POWER && !LAMP_FAULT)
    else $error("lamps wrong while outputs enabled");
  a_store_pulse: assert property ($rose(NV_WE) |=> !NV_WE)
    else $error("store write longer than one cycle");
  a_apb_ready: assert property (PSEL && !PENABLE |=> PREADY ##1 !PREADY)
    else $error("ready not a single cycle after setup");
  c_holdoff: cover property (NV_WE && NV_WFLAGS[GLT_NV_HOLDOFF]);
  c_relock: cover property ($rose(SAFE_OUT_A) && ACT_PRESENT);
  c_unlock: cover property ($fell(LOCK_DRIVE) && ACT_PRESENT);
endmodule

bind glt_ctrl glt_ctrl_monitor #(.HOLDOFF_CYC(HOLDOFF_CYC)) glt_ctrl_monitor_inst (
  .SYS_CLK(SYS_CLK), .RST_N(RST_N), .PSEL(PSEL), .PENABLE(PENABLE), .PREADY(PREADY),
  .ACT_PRESENT(ACT_PRESENT), .CHAIN_SAFE_IN_A(CHAIN_SAFE_IN_A), .HANDLE_AT_DETENT(HANDLE_AT_DETENT),
  .NV_WE(NV_WE), .NV_WFLAGS(NV_WFLAGS), .LOCK_DRIVE(LOCK_DRIVE), .SAFE_OUT_A(SAFE_OUT_A),
  .SAFE_OUT_B(SAFE_OUT_B), .LAMP_POWER(LAMP_POWER), .LAMP_FAULT(LAMP_FAULT));
`default_nettype wire

/* glt_ctrl_tb.sv */
// self-checking bench for the guard lock teach controller
`timescale 1ns/1ps
`default_nettype none
module glt_ctrl_tb import glt_pkg::*; ;
  localparam logic [31:0] CODE_A = 32'hA5A5_1001;
  localparam logic [31:0] CODE_C = 32'h0000_0C0D;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] code = 32'h1234_5678;
  logic        act = 1'b0;
  logic        chain_a = 1'b1;
  logic        chain_b = 1'b1;
  logic        lock_cmd = 1'b0;
  logic        handle = 1'b1;
  logic [31:0] prdata, nv_code, nv_new, nv_wcode, nv_wnew, q;
  logic [2:0]  nv_flags, nv_wflags;
  logic        pready, pslverr, nv_we, lock_sense, lock_drive, safe_a, safe_b, mism, e;
  wire  [2:0]  lamps;
  int          n_errors = 0;
  int          num_checks = 0;
  int          hi, rs, i;

  glt_ctrl #(.TEACH_CYC(34'h28), .OFFREQ_CYC(34'h3C), .HOLDOFF_CYC(34'h32), .TICK_CYC(24'h4)) glt_ctrl_inst (
    .SYS_CLK(clk), .RST_N(rst_n), .CE(1'b1), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
    .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
    .ACT_PRESENT(act), .ACT_CODE(code), .CHAIN_SAFE_IN_A(chain_a), .CHAIN_SAFE_IN_B(chain_b),
    .LOCK_CMD(lock_cmd), .HANDLE_AT_DETENT(handle), .LOCK_SENSE(lock_sense), .NV_FLAGS(nv_flags),
    .NV_CODE(nv_code), .NV_NEW_CODE(nv_new), .NV_WE(nv_we), .NV_WFLAGS(nv_wflags), .NV_WCODE(nv_wcode),
    .NV_WNEW_CODE(nv_wnew), .LOCK_DRIVE(lock_drive), .SAFE_OUT_A(safe_a), .SAFE_OUT_B(safe_b),
    .LAMP_POWER(lamps[0]), .LAMP_STATUS(lamps[1]), .LAMP_FAULT(lamps[2]));
  glt_far_model #(.FIRST_CODE(CODE_C)) glt_far_model_inst (
    .SYS_CLK(clk), .NV_WE(nv_we), .NV_WFLAGS(nv_wflags), .NV_WCODE(nv_wcode), .NV_WNEW_CODE(nv_wnew),
    .LOCK_DRIVE(lock_drive), .SAFE_OUT_A(safe_a), .SAFE_OUT_B(safe_b), .NV_FLAGS(nv_flags),
    .NV_CODE(nv_code), .NV_NEW_CODE(nv_new), .LOCK_SENSE(lock_sense), .CHAN_MISMATCH(mism));

  always #50 clk = ~clk;

  task automatic close_out;
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask

  task automatic chk1(input logic got, input logic exp);
    chk({31'h0, got}, {31'h0, exp});
  endtask

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (pready !== 1'b1 && k < 16);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin
      n_errors++;
      close_out();
    end
  endtask

  // status is polled over the bus, so a wait costs three cycles a try
  task automatic poll(input logic [6:0] st);
    int k;
    for (k = 0; k < 80; k++) begin
      apb(1'b0, GLT_STATUS_OFS, 32'h0);
      if (q[6:0] === st) break;
    end
    chk({25'h0, q[6:0]}, {25'h0, st});
    if (q[6:0] !== st) close_out();
  endtask

  // two sync stages, output flop and bolt travel all fit in twelve cycles
  task automatic settle;
    repeat (12) @(posedge clk);
  endtask

  task automatic blink(input int s);
    logic p;
    hi = 0;
    rs = 0;
    p = lamps[s];
    repeat (24) begin
      @(posedge clk);
      hi += int'(lamps[s]);
      rs += int'(lamps[s] && !p);
      p = lamps[s];
    end
  endtask

  task automatic pwr;
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
  endtask

  initial begin
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    apb(1'b0, GLT_CTRL_OFS, 32'h0);
    chk(q, 32'h8);
    apb(1'b0, 8'h08, 32'h0);
    chk1(e, 1'b1);
    chk(q, 32'h0);
    apb(1'b1, GLT_STATUS_OFS, 32'hFFFF_FFFF);
    chk1(e, 1'b0);
    act <= 1'b1;
    settle();
    chk1(lock_drive, 1'b1);
    chk1(safe_a, 1'b1);
    lock_cmd <= 1'b1;
    settle();
    chk1(lock_drive, 1'b0);
    chk1(safe_b, 1'b0);
    lock_cmd <= 1'b0;
    settle();
    chk1(safe_a, 1'b1);
    handle <= 1'b0;
    lock_cmd <= 1'b1;
    settle();
    lock_cmd <= 1'b0;
    settle();
    chk1(lock_drive, 1'b0);
    handle <= 1'b1;
    apb(1'b1, GLT_CTRL_OFS, 32'h4);
    settle();
    chk1(lock_drive, 1'b0);
    chk1(safe_a, 1'b1);
    lock_cmd <= 1'b1;
    settle();
    chk1(lock_drive, 1'b1);
    chain_a <= 1'b0;
    settle();
    chk1(safe_a, 1'b0);
    chk1(lamps[2], 1'b0);
    chk1(lamps[1], 1'b1);
    blink(0);
    chk(hi, 12);
    chk(rs, 1);
    chain_a <= 1'b1;
    chain_b <= 1'b0;
    settle();
    chk1(safe_a, 1'b0);
    chk1(lamps[1], 1'b1);
    blink(0);
    chk(rs, 1);
    chain_b <= 1'b1;
    act <= 1'b0;
    lock_cmd <= 1'b0;
    settle();
    chk1(safe_a, 1'b0);
    pwr();
    apb(1'b1, GLT_CTRL_OFS, 32'h9);
    act <= 1'b1;
    settle();
    poll(ST_RUN);
    chk1(safe_a, 1'b0);
    act <= 1'b0;
    settle();
    code <= CODE_C;
    act <= 1'b1;
    settle();
    chk1(safe_a, 1'b1);
    act <= 1'b0;
    pwr();
    apb(1'b1, GLT_CTRL_OFS, 32'hB);
    code <= CODE_A;
    act <= 1'b1;
    poll(ST_TEACH);
    chk1(lamps[0], 1'b0);
    chk1(lamps[2], 1'b1);
    blink(1);
    chk(rs, 1);
    poll(ST_OFFREQ);
    chk(nv_new, CODE_A);
    blink(1);
    chk(rs, 3);
    poll(ST_ABORT);
    chk({29'h0, nv_flags}, 32'h1);
    blink(2);
    chk(rs, 1);
    poll(ST_RUN);
    act <= 1'b0;
    pwr();
    apb(1'b1, GLT_CTRL_OFS, 32'hB);
    act <= 1'b1;
    poll(ST_OFFREQ);
    act <= 1'b0;
    pwr();
    apb(1'b1, GLT_CTRL_OFS, 32'hB);
    poll(ST_ACTIVATE);
    act <= 1'b1;
    poll(ST_HOLDOFF);
    chk(nv_code, CODE_A);
    chk({29'h0, nv_flags}, 32'h5);
    chk1(safe_a, 1'b0);
    blink(0);
    chk(rs, 1);
    pwr();
    poll(ST_HOLDOFF);
    for (i = 0; i < 200 && safe_a !== 1'b1; i++) begin
      @(posedge clk);
    end
    chk1(i >= 30 && i < 200, 1'b1);
    chk1(mism, 1'b0);
    close_out();
  end
endmodule
`default_nettype wire

/* glt_far_model.sv */
// far side model: persistent store, bolt mechanics and dual-channel monitor
`timescale 1ns/1ps
`default_nettype none
module glt_far_model #(
  parameter logic [31:0] FIRST_CODE = 32'h0000_0C0D
) (
  input  wire logic        SYS_CLK,
  input  wire logic        NV_WE,
  input  wire logic [2:0]  NV_WFLAGS,
  input  wire logic [31:0] NV_WCODE,
  input  wire logic [31:0] NV_WNEW_CODE,
  input  wire logic        LOCK_DRIVE,
  input  wire logic        SAFE_OUT_A,
  input  wire logic        SAFE_OUT_B,
  output var  logic [2:0]  NV_FLAGS,
  output var  logic [31:0] NV_CODE,
  output var  logic [31:0] NV_NEW_CODE,
  output var  logic        LOCK_SENSE,
  output var  logic        CHAN_MISMATCH
);
  logic [2:0]  flags_q = 3'h1;
  logic [31:0] code_q = FIRST_CODE;
  logic [31:0] new_q = 32'h0;
  logic [1:0]  bolt_q = 2'h0;
  logic        bad_q = 1'b0;
  // no reset input: the store keeps its word across every power cycle
  always @(posedge SYS_CLK) begin
    if (NV_WE) begin
      flags_q <= NV_WFLAGS;
      code_q <= NV_WCODE;
      new_q <= NV_WNEW_CODE;
    end
    bolt_q <= {bolt_q[0], LOCK_DRIVE};
    if (SAFE_OUT_A !== SAFE_OUT_B) begin
      bad_q <= 1'b1;
    end
  end
  assign NV_FLAGS = flags_q;
  assign NV_CODE = code_q;
  assign NV_NEW_CODE = new_q;
  assign LOCK_SENSE = bolt_q[1];
  assign CHAN_MISMATCH = bad_q;
endmodule
`default_nettype wire

/* glt_pkg.sv */
// shared constants and types of the guard lock teach controller
package glt_pkg;

  // clock and timing, each time in its own unit with the derived cycle count
  localparam longint unsigned GLT_CLK_HZ        = 10_000_000;
  localparam longint unsigned GLT_TEACH_S       = 10;
  localparam longint unsigned GLT_TEACH_CYC     = GLT_TEACH_S * GLT_CLK_HZ;
  localparam longint unsigned GLT_OFFREQ_MIN    = 5;
  localparam longint unsigned GLT_OFFREQ_CYC    = GLT_OFFREQ_MIN * 60 * GLT_CLK_HZ;
  localparam longint unsigned GLT_HOLDOFF_MIN   = 10;
  localparam longint unsigned GLT_HOLDOFF_CYC   = GLT_HOLDOFF_MIN * 60 * GLT_CLK_HZ;
  localparam longint unsigned GLT_SLOW_HZ       = 1;
  localparam longint unsigned GLT_FAST_HZ       = 3;
  // one tick is half a fast period; the slow blink toggles every third tick
  localparam longint unsigned GLT_TICK_CYC      = GLT_CLK_HZ / (2 * GLT_FAST_HZ);
  localparam int              GLT_TICKS_PER_SLOW = 3;
  localparam int              GLT_TMR_W         = 34;
  localparam int              GLT_TICK_W        = 24;
  localparam int              GLT_ABORT_FLASHES = 5;
  localparam int              GLT_INIT_WAIT     = 3;
  localparam int              GLT_CODE_W        = 32;

  // register offsets (byte addresses)
  localparam logic [7:0] GLT_CTRL_OFS   = 8'h00;
  localparam logic [7:0] GLT_STATUS_OFS = 8'h04;

  // control register fields and reset value
  localparam int          GLT_CTRL_INDIV_BIT  = 0;
  localparam int          GLT_CTRL_REPEAT_BIT = 1;
  localparam int          GLT_CTRL_P2LOCK_BIT = 2;
  localparam int          GLT_CTRL_LOCKMON_BIT = 3;
  localparam int          GLT_CTRL_W          = 4;
  localparam logic [3:0]  GLT_CTRL_RESET      = 4'h8;

  // status register fields
  localparam int GLT_ST_STATE_LSB   = 0;
  localparam int GLT_ST_PAIRED_BIT  = 8;
  localparam int GLT_ST_PENDING_BIT = 9;
  localparam int GLT_ST_HOLDOFF_BIT = 10;
  localparam int GLT_ST_GUARD_BIT   = 11;
  localparam int GLT_ST_LOCKED_BIT  = 12;
  localparam int GLT_ST_SAFE_BIT    = 13;
  localparam int GLT_ST_CHAIN_BIT   = 14;
  localparam int GLT_ST_HANDLE_BIT  = 15;

  // persistent flag word fields
  localparam int GLT_NV_PAIRED  = 0;
  localparam int GLT_NV_PENDING = 1;
  localparam int GLT_NV_HOLDOFF = 2;

  typedef enum logic [6:0] {
    ST_INIT     = 7'h01,
    ST_RUN      = 7'h02,
    ST_TEACH    = 7'h04,
    ST_OFFREQ   = 7'h08,
    ST_ABORT    = 7'h10,
    ST_ACTIVATE = 7'h20,
    ST_HOLDOFF  = 7'h40
  } glt_state_t;

endpackage
